// ### shared/dsub_pkg.sv
// dsub_pkg: constants for the data subchannel control block.
// assumes a 40 MHz aclk and a 32-bit AXI4-Lite register port.
package dsub_pkg;
   localparam int unsigned CLK_NS      = 25;
   localparam int unsigned PHASE_NS    = 125;
   localparam int unsigned PHASE_CYC   = (PHASE_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned TEST_NS     = 250;
   localparam int unsigned TEST_CYC    = (TEST_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0]  PH_LAST     = 4'h8;
   localparam logic [3:0]  PH_ADDR     = 4'h2;
   localparam logic [3:0]  PH_DATA     = 4'h5;
   localparam logic [3:0]  PH_TX_ON    = 4'h4;
   localparam logic [3:0]  PH_TX_OFF   = 4'h1;

   localparam logic [7:0]  OFF_CTRL    = 8'h00;
   localparam logic [7:0]  OFF_WCOUNT  = 8'h04;
   localparam logic [7:0]  OFF_STATUS  = 8'h08;

   localparam int unsigned CTRL_EN     = 0;
   localparam int unsigned CTRL_CYCLE  = 1;
   localparam int unsigned CTRL_DISC   = 2;
   localparam int unsigned CTRL_HCLR   = 3;
   localparam int unsigned CTRL_TEST   = 4;

   localparam int unsigned ST_HALT     = 0;
   localparam int unsigned ST_ACC      = 1;
   localparam int unsigned ST_SEL      = 2;
   localparam int unsigned ST_PERR     = 3;
   localparam int unsigned ST_ZERO     = 4;
   localparam int unsigned ST_TRES     = 5;
   localparam int unsigned ST_TBUSY    = 6;
   localparam int unsigned ST_BUSY     = 7;

   localparam logic [15:0] WCOUNT_RST  = 16'h0000;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {FN_INPUT, FN_OUTPUT, FN_INCR, FN_SPARE} dsub_fn_t;
endpackage

// ### rtl/dsub_sync.sv
// dsub_sync: two-flop synchroniser for a bus of unrelated pin levels.
// assumes each bit is a slow level; no word coherence between bits.
`timescale 1ns/1ps
module dsub_sync
   import dsub_pkg::*;
#(
   parameter int unsigned W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } dsub_sync_t;

   dsub_sync_t s_q, s_d;

   always_comb begin
      s_d.meta = d;
      s_d.sync = s_q.meta;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= {INIT, INIT};
      end else begin
         s_q <= s_d;
      end
   end

   assign q = s_q.sync;
endmodule

// ### rtl/dsub_ctrl.sv
// dsub_ctrl: control side of a data subchannel on a multiplex memory channel.
// assumes unit pins are asynchronous; grant and other_accept come from aclk logic.
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
module dsub_ctrl
   import dsub_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        op_request_n,
   input  wire logic        halt_request_n,
   input  wire logic        skip_response,
   input  wire logic [1:0]  function_code,
   input  wire logic [23:0] data_in,
   input  wire logic        channel_grant,
   input  wire logic        other_accept,
   output logic             request_accepted,
   output logic             subchannel_selected,
   output logic             address_done,
   output logic             data_out_strobe,
   output logic             data_in_strobe,
   output logic             parity_error,
   output logic             zero_count,
   output logic             timing_x,
   output logic             timing_y,
   output logic             halt_done_out,
   output logic             skip_on_signal_test
);
   typedef struct packed {
      logic [3:0]  phase;
      logic [2:0]  div;
      logic        busy;
      logic        acc;
      logic        sel;
      logic        halt;
      logic        perr;
      logic        perr_seen;
      logic        zero;
      logic        odd;
      dsub_fn_t    fn;
      logic [15:0] wcount;
      logic        en;
      logic        cyc;
      logic        tbusy;
      logic        tres;
      logic [3:0]  tcnt;
      logic        addr_done;
      logic        dout;
      logic        din;
      logic        awv;
      logic [7:0]  awaddr;
      logic        wv;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } dsub_state_t;

   dsub_state_t s_q, s_d;
   logic [28:0] pins_s;
   logic        req_act;
   logic        halt_act;
   logic        resp_s;
   logic [1:0]  fn_s;
   logic [23:0] data_s;

   // pins only reach logic after two flops; requests idle high
   dsub_sync #(
      .W    (29),
      .INIT (29'h0000_0003)
   ) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       ({data_in, function_code, skip_response, halt_request_n, op_request_n}),
      .q       (pins_s)
   );

   assign req_act  = !pins_s[0];
   assign halt_act = !pins_s[1];
   assign resp_s   = pins_s[2];
   assign fn_s     = pins_s[4:3];
   assign data_s   = pins_s[28:5];

   logic        tick;
   logic        start;
   logic        wr_go;
   logic [3:0]  ph_next;
   logic [15:0] wc_dec;
   logic [31:0] status;

   assign tick    = s_q.busy && (s_q.div == 3'(PHASE_CYC - 1));
   assign ph_next = s_q.phase + 4'h1;
   assign wc_dec  = s_q.wcount - 16'h0001;
   // a new word needs an idle cycle first, so halt can take effect between words
   assign start   = !s_q.busy && s_q.en && !s_q.halt && req_act && channel_grant;
   assign wr_go   = s_q.awv && s_q.wv && !s_q.bvalid;

   always_comb begin
      status          = '0;
      status[ST_HALT]  = s_q.halt;
      status[ST_ACC]   = s_q.acc;
      status[ST_SEL]   = s_q.sel;
      status[ST_PERR]  = s_q.perr_seen;
      status[ST_ZERO]  = s_q.zero;
      status[ST_TRES]  = s_q.tres;
      status[ST_TBUSY] = s_q.tbusy;
      status[ST_BUSY]  = s_q.busy;
   end

   always_comb begin
      s_d           = s_q;
      s_d.addr_done = 1'b0;
      s_d.dout      = 1'b0;
      s_d.din       = 1'b0;

      // idle with no new word: accepted is let go, so a held request keeps it up
      if (!s_q.busy && !start) begin
         s_d.acc = 1'b0;
      end

      // channel cycle, nine phases
      if (s_q.busy) begin
         s_d.div = tick ? 3'h0 : s_q.div + 3'h1;
      end
      if (start) begin
         s_d.busy  = 1'b1;
         s_d.phase = 4'h0;
         s_d.div   = 3'h0;
         s_d.acc   = 1'b1;
         s_d.fn    = dsub_fn_t'(fn_s);
      end else if (tick) begin
         if (s_q.phase == PH_LAST) begin
            s_d.busy = 1'b0;
         end else begin
            s_d.phase = ph_next;
         end
         if (ph_next == PH_ADDR) begin
            s_d.addr_done = 1'b1;
            // a request still low keeps accepted high across words
            s_d.acc = req_act;
         end
         if (ph_next == PH_DATA) begin
            if (s_q.fn == FN_OUTPUT) begin
               s_d.dout = 1'b1;
            end else begin
               s_d.din = 1'b1;
            end
            if (s_q.fn == FN_INPUT) begin
               s_d.perr = ~^data_s;
               if (~^data_s) begin
                  s_d.perr_seen = 1'b1;
               end
            end
            if (s_q.fn == FN_INCR) begin
               s_d.wcount = wc_dec;
               s_d.zero   = (wc_dec == 16'h0000);
               s_d.odd    = !s_q.odd;
               if ((wc_dec == 16'h0000) && s_q.odd && !s_q.cyc) begin
                  s_d.halt = 1'b1;
               end
            end
         end
      end

      // selection is lost only to another subchannel; a fresh start wins
      if (other_accept && !start) begin
         s_d.sel = 1'b0;
      end else if (start) begin
         s_d.sel = 1'b1;
      end

      // skip test: drive the test line, sample the answer at the end
      if (s_q.tbusy) begin
         s_d.tcnt = s_q.tcnt + 4'h1;
         if (s_q.tcnt == 4'(TEST_CYC - 1)) begin
            s_d.tbusy = 1'b0;
            s_d.tres  = resp_s;
         end
      end

      // register write
      if (s_axi_awvalid && s_axi_awready) begin
         s_d.awv    = 1'b1;
         s_d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_d.wv    = 1'b1;
         s_d.wdata = s_axi_wdata;
         s_d.wstrb = s_axi_wstrb;
      end
      if (wr_go) begin
         s_d.awv    = 1'b0;
         s_d.wv     = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp  = RESP_OKAY;
         unique case (s_q.awaddr)
            OFF_CTRL: begin
               if (s_q.wstrb[0]) begin
                  s_d.en  = s_q.wdata[CTRL_EN];
                  s_d.cyc = s_q.wdata[CTRL_CYCLE];
                  if (s_q.wdata[CTRL_TEST] && !s_q.tbusy) begin
                     s_d.tbusy = 1'b1;
                     s_d.tcnt  = 4'h0;
                  end
               end
            end
            OFF_WCOUNT: begin
               if (s_q.wstrb[0]) begin
                  s_d.wcount[7:0] = s_q.wdata[7:0];
               end
               if (s_q.wstrb[1]) begin
                  s_d.wcount[15:8] = s_q.wdata[15:8];
               end
               s_d.odd = 1'b0;
            end
            OFF_STATUS: begin
               // write one clears; a same-cycle parity event still lands
               if (s_q.wstrb[0] && s_q.wdata[ST_PERR] && !s_d.din) begin
                  s_d.perr_seen = 1'b0;
               end
            end
            default: begin
               s_d.bresp = RESP_SLVERR;
            end
         endcase
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end

      // halt: clear first so every setting source wins over it
      if (wr_go && (s_q.awaddr == OFF_CTRL) && s_q.wstrb[0] && s_q.wdata[CTRL_HCLR]) begin
         s_d.halt = 1'b0;
      end
      if (halt_act) begin
         s_d.halt = 1'b1;
      end
      if (wr_go && (s_q.awaddr == OFF_CTRL) && s_q.wstrb[0] && s_q.wdata[CTRL_DISC]) begin
         s_d.halt = 1'b1;
      end
      if (tick && (ph_next == PH_DATA) && (s_q.fn == FN_INCR) && (wc_dec == 16'h0000)
          && s_q.odd && !s_q.cyc) begin
         s_d.halt = 1'b1;
      end

      // register read
      if (s_axi_arvalid && s_axi_arready) begin
         s_d.rvalid = 1'b1;
         s_d.rresp  = RESP_OKAY;
         unique case (s_axi_araddr)
            OFF_CTRL: begin
               s_d.rdata = {27'h0, 1'b0, 2'h0, s_q.cyc, s_q.en};
            end
            OFF_WCOUNT: begin
               s_d.rdata = {16'h0, s_q.wcount};
            end
            OFF_STATUS: begin
               s_d.rdata = status;
            end
            default: begin
               s_d.rdata = 32'h0;
               s_d.rresp = RESP_SLVERR;
            end
         endcase
      end else if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q        <= '0;
         s_q.fn     <= FN_INPUT;
         s_q.wcount <= WCOUNT_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign s_axi_awready       = !s_q.awv && !s_q.bvalid;
   assign s_axi_wready        = !s_q.wv && !s_q.bvalid;
   assign s_axi_bvalid        = s_q.bvalid;
   assign s_axi_bresp         = s_q.bresp;
   assign s_axi_arready       = !s_q.rvalid;
   assign s_axi_rvalid        = s_q.rvalid;
   assign s_axi_rdata         = s_q.rdata;
   assign s_axi_rresp         = s_q.rresp;
   assign request_accepted    = s_q.acc;
   assign subchannel_selected = s_q.sel;
   assign address_done        = s_q.addr_done;
   assign data_out_strobe     = s_q.dout;
   assign data_in_strobe      = s_q.din;
   assign parity_error        = s_q.perr;
   assign zero_count          = s_q.zero;
   assign timing_x            = s_q.busy && ((s_q.phase >= PH_TX_ON) || (s_q.phase <= PH_TX_OFF));
   assign timing_y            = s_q.busy;
   // access complete means no channel cycle is in flight
   assign halt_done_out       = s_q.halt && !s_q.busy;
   assign skip_on_signal_test = s_q.tbusy;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_cycle_start;
      $rose(timing_y);
   endsequence
   sequence s_tx_shape;
      timing_x ##10 !timing_x ##10 timing_x;
   endsequence

   property p_ty_len;
      s_cycle_start |-> ##44 timing_y ##1 !timing_y;
   endproperty
   a_ty_len: assert property (p_ty_len) else $error("second pulse length wrong");

   property p_tx_shape;
      s_cycle_start |-> s_tx_shape;
   endproperty
   a_tx_shape: assert property (p_tx_shape) else $error("first pulse shape wrong");

   property p_addr_done;
      s_cycle_start |-> request_accepted ##10 address_done;
   endproperty
   a_addr_done: assert property (p_addr_done) else $error("address done misplaced");

   property p_acc_hold;
      address_done && $past(req_act) |-> request_accepted;
   endproperty
   a_acc_hold: assert property (p_acc_hold) else $error("accepted dropped");

   property p_dout;
      data_out_strobe |-> subchannel_selected && timing_y && (s_q.phase == PH_DATA);
   endproperty
   a_dout: assert property (p_dout) else $error("output strobe misplaced");

   property p_parity;
      data_in_strobe && (s_q.fn == FN_INPUT) |-> parity_error == $past(~^data_s);
   endproperty
   a_parity: assert property (p_parity) else $error("parity flag wrong");

   property p_halt_req;
      halt_act |=> s_q.halt;
   endproperty
   a_halt_req: assert property (p_halt_req) else $error("halt request lost");

   property p_halt_out;
      halt_done_out |-> s_q.halt && !timing_y;
   endproperty
   a_halt_out: assert property (p_halt_out) else $error("halt output early");

   property p_sel_lost;
      other_accept && !start |=> !subchannel_selected;
   endproperty
   a_sel_lost: assert property (p_sel_lost) else $error("selection kept");

   property p_test;
      $rose(skip_on_signal_test) |->
         skip_on_signal_test[*8] ##1 skip_on_signal_test[*2] ##1 !skip_on_signal_test;
   endproperty
   a_test: assert property (p_test) else $error("test window wrong");
endmodule

// ### tb/dsub_unit.sv
// dsub_unit: behavioural external unit on the subchannel pins.
// assumes the bench pulses load with a word count; pins move after aclk edges.
`timescale 1ns/1ps
module dsub_unit
   import dsub_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        load,
   input  wire logic [3:0]  want,
   input  wire logic [1:0]  fn,
   input  wire logic [23:0] word,
   input  wire logic        halt_cmd,
   input  wire logic        answer,
   input  wire logic        request_accepted,
   input  wire logic        subchannel_selected,
   input  wire logic        address_done,
   input  wire logic        data_in_strobe,
   input  wire logic        data_out_strobe,
   input  wire logic        halt_done_out,
   input  wire logic        skip_on_signal_test,
   output logic             op_request_n,
   output logic             halt_request_n,
   output logic             skip_response,
   output logic [1:0]       function_code,
   output logic [23:0]      data_in,
   output logic [7:0]       got
);
   logic [3:0] left;
   logic [3:0] pend;
   logic       hold_q;
   initial begin
      left = '0;
      pend = '0;
      got = '0;
      hold_q = 1'b0;
   end
   always @(posedge aclk) begin
      if (load) begin
         left <= want;
         pend <= want;
      end else begin
         if (address_done && request_accepted && left != 0) left <= left - 1;
         if ((data_in_strobe || data_out_strobe) && subchannel_selected && pend != 0) begin
            pend <= pend - 1;
            got <= got + 1;
         end
      end
      // held until the halt is seen, then let go
      if (halt_done_out) hold_q <= 1'b0;
      else if (halt_cmd) hold_q <= 1'b1;
   end
   assign op_request_n   = (left == 0);
   assign halt_request_n = !hold_q;
   assign skip_response  = skip_on_signal_test ? answer : !answer;
   assign function_code  = fn;
   // data turns over once no word is owed
   assign data_in        = (pend != 0) ? word : ~word;
endmodule

// ### tb/dsub_ctrl_tb.sv
// dsub_ctrl_tb: register-level bench for dsub_ctrl with a model unit.
// assumes channel_grant always high; 25 ns aclk.
`timescale 1ns/1ps
module dsub_ctrl_tb
   import dsub_pkg::*;
;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, grant, other;
   logic [7:0] awaddr, araddr, got;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp, fc, fn_r;
   logic load, halt_cmd, answer, oreq_n, hreq_n, sresp;
   logic [3:0] want_r;
   logic [23:0] din, word_r;
   logic acc, sel, adone, dout_s, din_s, perr, zc, tx, ty, hdone, stest, acc_p;
   int bad_count, n_checks, cnt[7], sv[7];
   initial begin
      aclk = 0;
      forever #12.5 aclk = ~aclk;
   end
   dsub_ctrl uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .op_request_n(oreq_n), .halt_request_n(hreq_n),
      .skip_response(sresp), .function_code(fc), .data_in(din), .channel_grant(grant),
      .other_accept(other), .request_accepted(acc), .subchannel_selected(sel),
      .address_done(adone), .data_out_strobe(dout_s), .data_in_strobe(din_s),
      .parity_error(perr), .zero_count(zc), .timing_x(tx), .timing_y(ty),
      .halt_done_out(hdone), .skip_on_signal_test(stest));
   dsub_unit unit (.aclk(aclk), .load(load), .want(want_r), .fn(fn_r), .word(word_r),
      .halt_cmd(halt_cmd), .answer(answer), .request_accepted(acc),
      .subchannel_selected(sel), .address_done(adone), .data_in_strobe(din_s),
      .data_out_strobe(dout_s), .halt_done_out(hdone), .skip_on_signal_test(stest),
      .op_request_n(oreq_n), .halt_request_n(hreq_n), .skip_response(sresp),
      .function_code(fc), .data_in(din), .got(got));
   always @(posedge aclk) begin
      cnt[0] += (ty === 1'b1);
      cnt[1] += (ty === 1'b1 && tx === 1'b0);
      cnt[2] += (adone === 1'b1);
      cnt[3] += (acc_p === 1'b1 && acc === 1'b0);
      cnt[4] += (din_s === 1'b1);
      cnt[5] += (dout_s === 1'b1);
      cnt[6] += (stest === 1'b1);
      acc_p = acc;
   end
   function automatic logic [31:0] d(input int i);
      return cnt[i] - sv[i];
   endfunction
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic tick(inout int n);
      @(posedge aclk);
      n++;
      if (n > 600) begin
         bad_count++;
         test_done();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      int n;
      logic ak, wk;
      n = 0;
      ak = 0;
      wk = 0;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ak && wk)) begin
         tick(n);
         if (awvalid && awready === 1'b1) begin
            ak = 1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready === 1'b1) begin
            wk = 1;
            wvalid <= 1'b0;
         end
      end
      do tick(n); while (bvalid !== 1'b1);
      chk(bresp, er);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input logic [1:0] er);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do tick(n); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do tick(n); while (rvalid !== 1'b1);
      chk(rdata & m, e);
      chk(rresp, er);
   endtask
   // start n words, wait for the last strobe, then let the cycle drain
   task automatic go(input logic [1:0] f, input logic [23:0] w, input logic [3:0] k);
      int n;
      logic [7:0] g0;
      n = 0;
      g0 = got;
      sv = cnt;
      fn_r <= f;
      word_r <= w;
      want_r <= k;
      load <= 1'b1;
      @(posedge aclk);
      load <= 1'b0;
      while (got !== g0 + k) tick(n);
      repeat (60) @(posedge aclk);
      chk(got - g0, k);
   endtask
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, other, load, halt_cmd} = '0;
      {awaddr, araddr, wdata, fn_r, word_r, want_r, answer, acc_p} = '0;
      grant = 1'b1;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(OFF_CTRL, '1, 0, RESP_OKAY);
      rd(OFF_WCOUNT, '1, WCOUNT_RST, RESP_OKAY);
      rd(OFF_STATUS, '1, 0, RESP_OKAY);
      rd(8'h0c, '1, 0, RESP_SLVERR);
      wr(8'h0c, 1, RESP_SLVERR);
      wr(OFF_WCOUNT, 32'h0001_1234, RESP_OKAY);
      rd(OFF_WCOUNT, '1, 32'h1234, RESP_OKAY);
      wr(OFF_CTRL, 1, RESP_OKAY);
      $display("test registers done");
      go(FN_INPUT, 24'h000001, 1);
      chk(d(0), 9 * PHASE_CYC);
      chk(d(1), 2 * PHASE_CYC);
      chk(d(2), 1);
      chk(d(3), 1);
      chk(d(4), 1);
      chk(perr, 0);
      chk(sel, 1);
      other <= 1'b1;
      @(posedge aclk);
      other <= 1'b0;
      repeat (2) @(posedge aclk);
      chk(sel, 0);
      go(FN_INPUT, 24'h000003, 2);
      chk(d(3), 1);
      chk(d(2), 2);
      chk(perr, 1);
      rd(OFF_STATUS, 32'h8, 32'h8, RESP_OKAY);
      go(FN_OUTPUT, 24'h0, 1);
      chk(d(5), 1);
      chk(d(4), 0);
      $display("test transfers done");
      wr(OFF_WCOUNT, 2, RESP_OKAY);
      go(FN_INCR, 24'h0, 2);
      chk(d(4), 2);
      chk(zc, 1);
      chk(hdone, 1);
      rd(OFF_STATUS, 32'h1, 32'h1, RESP_OKAY);
      wr(OFF_CTRL, 32'h9, RESP_OKAY);
      chk(hdone, 0);
      $display("test increment done");
      halt_cmd <= 1'b1;
      @(posedge aclk);
      halt_cmd <= 1'b0;
      repeat (10) @(posedge aclk);
      chk(hdone, 1);
      // halted: the request must wait for the halt clear
      fn_r <= FN_INPUT;
      want_r <= 4'h1;
      load <= 1'b1;
      @(posedge aclk);
      load <= 1'b0;
      sv = cnt;
      repeat (80) @(posedge aclk);
      chk(d(4), 0);
      wr(OFF_CTRL, 32'h9, RESP_OKAY);
      repeat (80) @(posedge aclk);
      chk(d(4), 1);
      // disconnect while a cycle runs: halt output waits for it
      fn_r <= FN_INPUT;
      load <= 1'b1;
      @(posedge aclk);
      load <= 1'b0;
      repeat (8) @(posedge aclk);
      wr(OFF_CTRL, 32'h5, RESP_OKAY);
      chk(hdone, 0);
      repeat (60) @(posedge aclk);
      chk(hdone, 1);
      wr(OFF_CTRL, 32'h9, RESP_OKAY);
      $display("test halt done");
      for (int v = 1; v >= 0; v--) begin
         answer <= v[0];
         sv = cnt;
         wr(OFF_CTRL, 32'h11, RESP_OKAY);
         repeat (20) @(posedge aclk);
         chk(d(6), TEST_CYC);
         rd(OFF_STATUS, 32'h20, v << ST_TRES, RESP_OKAY);
      end
      $display("test skip done");
      test_done();
   end
endmodule
